// ### pkg/i2c_seq_pkg.sv
package i2c_seq_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  // Instruction cycle of the host core, counter runs at twice this rate
  localparam int TCY_NS = 80;
  localparam int TCY_CYC = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] TICK_DIV_LAST = 2'((TCY_CYC / 2) - 1);
  // Rewrite window after a buffer write while shifting, 2 instruction cycles
  localparam int REWRITE_WINDOW_TCY = 2;
  localparam logic [3:0] REWRITE_WINDOW_CYC = 4'(REWRITE_WINDOW_TCY * TCY_CYC);

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] DATA_BUFFER_OFS = 8'h00;
  localparam logic [7:0] RELOAD_VALUE_OFS = 8'h04;
  localparam logic [7:0] SEQ_CONTROL_OFS = 8'h08;
  localparam logic [7:0] PORT_STATUS_OFS = 8'h0c;
  localparam logic [7:0] EVENT_FLAGS_OFS = 8'h10;

  // Sequence control bits
  localparam int START_REQ_POS = 0;
  localparam int RESTART_REQ_POS = 1;
  localparam int RX_EN_POS = 3;
  localparam int ACK_STAT_POS = 6;
  // Port status bits
  localparam int BUF_FULL_POS = 0;
  localparam int START_DET_POS = 3;
  // Event flag bits, write one to clear
  localparam int PORT_IRQ_POS = 0;
  localparam int COLL_IRQ_POS = 1;
  localparam int WR_COLL_POS = 2;
  localparam int RX_OVF_POS = 3;

  localparam logic [6:0] RELOAD_RST = 7'h00;
  localparam logic [7:0] BUF_RST = 8'h00;
  localparam logic [3:0] LAST_BIT = 4'h8;
  localparam logic [3:0] ACK_BIT = 4'h8;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_ST_WAIT = 4'h1,
    S_ST_HOLD = 4'h2,
    S_RS_LOW = 4'h3,
    S_RS_SDA = 4'h4,
    S_RS_REL = 4'h5,
    S_RS_HIGH = 4'h6,
    S_RS_SDALOW = 4'h7,
    S_TX_LOW = 4'h8,
    S_TX_REL = 4'h9,
    S_TX_HIGH = 4'ha,
    S_RX_LOW = 4'hb,
    S_RX_REL = 4'hc,
    S_RX_HIGH = 4'hd
  } seq_state_t;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } line_drive_t;

endpackage

// ### hw/i2c_master_condition_sequencer.sv
// Summary of operation
// - Start request, both lines high: reload, count
// - Timeout, lines high: SDA low, start detected
// - Second timeout: clear request, stop counter
// - Start collision sets flag, aborts to idle
// - Buffer write during conditions/receive: write collision
// - Control writes ignored while condition runs
// - Restart: SCL low, short reload, SDA released
// - SDA high: release SCL, both high, SDA low
// - Restart end: clear bit, flag after timeout
// - Restart ignored while another event runs
// - Restart collision on SDA low or SCL fall
// - Idle buffer write sets full, starts transmit
// - Bits MSB first, SCL low then high
// - Eighth falling edge: clear full, release SDA
// - Ninth falling edge samples acknowledge status
// - After ninth clock: interrupt, counter stops, SCL low
// - Write while shifting: collision, early rewrite kept
// - Receive enable accepted only in idle
// - Receive toggles SCL per rollover, shifts SDA
// - Eighth received clock: copy, full, interrupt, stop
// - Buffer read clears full during reception
// - Byte arrives with full set: overflow flag
// - Counter counts to zero and stops there
// - Released SCL suspends counter until sampled high
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module i2c_master_condition_sequencer
  import i2c_seq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_i,
  input wire logic sda_i,
  output line_drive_t line_drv
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    seq_state_t st;
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic scl_lvl;
    logic sda_lvl;
    logic [1:0] div;
    logic [6:0] cnt;
    logic [3:0] bitn;
    logic [7:0] dbuf;
    logic [7:0] sh;
    logic [6:0] reload;
    logic start_req;
    logic restart_req;
    logic rx_en;
    logic ack_stat;
    logic buf_full;
    logic start_det;
    logic irq;
    logic bcol;
    logic wr_coll;
    logic ovf;
    logic scl_drv;
    logic sda_drv;
    logic [3:0] since_wr;
    logic [31:0] rdata;
  } state_t;

  state_t r;
  state_t n;

  function automatic logic counting(input seq_state_t s);
    case (s)
      S_ST_WAIT, S_ST_HOLD, S_RS_SDA, S_RS_HIGH, S_RS_SDALOW,
      S_TX_LOW, S_TX_HIGH, S_RX_LOW, S_RX_HIGH: counting = 1'b1;
      default: counting = 1'b0;
    endcase
  endfunction

  function automatic logic in_condition(input seq_state_t s);
    case (s)
      S_ST_WAIT, S_ST_HOLD, S_RS_LOW, S_RS_SDA, S_RS_REL, S_RS_HIGH, S_RS_SDALOW: in_condition = 1'b1;
      default: in_condition = 1'b0;
    endcase
  endfunction

  function automatic logic in_rx(input seq_state_t s);
    in_rx = (s == S_RX_LOW) || (s == S_RX_REL) || (s == S_RX_HIGH);
  endfunction

  function automatic logic in_tx(input seq_state_t s);
    in_tx = (s == S_TX_LOW) || (s == S_TX_REL) || (s == S_TX_HIGH);
  endfunction

  logic tick;
  logic tmo;
  logic wr;
  logic rd;
  logic buf_wr;
  logic go_tx;
  logic mapped;

  assign tick = (r.div == 2'h0);
  assign tmo = counting(r.st) && tick && (r.cnt == 7'h00);
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign buf_wr = wr && (paddr == DATA_BUFFER_OFS);
  assign mapped = (paddr == DATA_BUFFER_OFS) || (paddr == RELOAD_VALUE_OFS) || (paddr == SEQ_CONTROL_OFS) ||
                  (paddr == PORT_STATUS_OFS) || (paddr == EVENT_FLAGS_OFS);

  // ------------------------------------------------------------
  // APB answer
  // ------------------------------------------------------------
  // Zero wait states; read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = r.rdata;
  assign line_drv.scl_o = 1'b0;
  assign line_drv.sda_o = 1'b0;
  assign line_drv.scl_oe = r.scl_drv;
  assign line_drv.sda_oe = r.sda_drv;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    n = r;
    go_tx = 1'b0;

    // Line sampling; a change counts once the last two stages agree
    n.scl_sync = {r.scl_sync[1:0], scl_i};
    n.sda_sync = {r.sda_sync[1:0], sda_i};
    if (r.scl_sync[2] == r.scl_sync[1]) begin
      n.scl_lvl = r.scl_sync[2];
    end
    if (r.sda_sync[2] == r.sda_sync[1]) begin
      n.sda_lvl = r.sda_sync[2];
    end

    // Half instruction cycle tick
    n.div = tick ? TICK_DIV_LAST : r.div - 2'h1;
    if (counting(r.st) && tick && (r.cnt != 7'h00)) begin
      n.cnt = r.cnt - 7'h01;
    end
    if (r.since_wr != REWRITE_WINDOW_CYC) begin
      n.since_wr = r.since_wr + 4'h1;
    end

    // Read data captured in setup phase
    if (psel && !penable && !pwrite) begin
      n.rdata = 32'h0000_0000;
      case (paddr)
        DATA_BUFFER_OFS: n.rdata[7:0] = r.dbuf;
        RELOAD_VALUE_OFS: n.rdata[6:0] = r.reload;
        SEQ_CONTROL_OFS: begin
          n.rdata[START_REQ_POS] = r.start_req;
          n.rdata[RESTART_REQ_POS] = r.restart_req;
          n.rdata[RX_EN_POS] = r.rx_en;
          n.rdata[ACK_STAT_POS] = r.ack_stat;
        end
        PORT_STATUS_OFS: begin
          n.rdata[BUF_FULL_POS] = r.buf_full;
          n.rdata[START_DET_POS] = r.start_det;
        end
        EVENT_FLAGS_OFS: begin
          n.rdata[PORT_IRQ_POS] = r.irq;
          n.rdata[COLL_IRQ_POS] = r.bcol;
          n.rdata[WR_COLL_POS] = r.wr_coll;
          n.rdata[RX_OVF_POS] = r.ovf;
        end
        default: n.rdata = 32'h0000_0000;
      endcase
    end

    // Software side; hardware sets below win over these clears
    if (rd && (paddr == DATA_BUFFER_OFS) && !in_tx(r.st)) begin
      n.buf_full = 1'b0;
    end
    if (wr && (paddr == RELOAD_VALUE_OFS)) begin
      n.reload = pwdata[6:0];
    end
    if (wr && (paddr == EVENT_FLAGS_OFS)) begin
      n.irq = r.irq && !pwdata[PORT_IRQ_POS];
      n.bcol = r.bcol && !pwdata[COLL_IRQ_POS];
      n.wr_coll = r.wr_coll && !pwdata[WR_COLL_POS];
      n.ovf = r.ovf && !pwdata[RX_OVF_POS];
    end
    // No queueing: requests only taken in idle with none pending
    if (wr && (paddr == SEQ_CONTROL_OFS) && !in_condition(r.st) && (r.st == S_IDLE) &&
        !r.start_req && !r.restart_req && !r.rx_en) begin
      n.start_req = pwdata[START_REQ_POS];
      n.restart_req = pwdata[RESTART_REQ_POS];
      n.rx_en = pwdata[RX_EN_POS];
    end
    if (buf_wr) begin
      if (in_condition(r.st) || in_rx(r.st) || r.rx_en || r.start_req || r.restart_req) begin
        n.wr_coll = 1'b1;
      end else if (in_tx(r.st)) begin
        n.wr_coll = 1'b1;
        if (r.since_wr != REWRITE_WINDOW_CYC) begin
          n.dbuf = pwdata[7:0];
        end
      end else begin
        n.dbuf = pwdata[7:0];
        n.buf_full = 1'b1;
        n.since_wr = 4'h0;
        go_tx = 1'b1;
      end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    case (r.st)
      S_IDLE: begin
        if (go_tx) begin
          n.sh = pwdata[7:0];
          n.bitn = 4'h0;
          n.scl_drv = 1'b1;
          n.sda_drv = !pwdata[7];
          n.cnt = r.reload;
          n.st = S_TX_LOW;
        end else if (r.start_req) begin
          if (!r.scl_lvl && !r.sda_lvl) begin
            n.bcol = 1'b1;
            n.start_req = 1'b0;
          end else if (r.scl_lvl && r.sda_lvl) begin
            n.cnt = r.reload;
            n.start_det = 1'b0;
            n.scl_drv = 1'b0;
            n.sda_drv = 1'b0;
            n.st = S_ST_WAIT;
          end
        end else if (r.restart_req) begin
          n.scl_drv = 1'b1;
          n.start_det = 1'b0;
          n.st = S_RS_LOW;
        end else if (r.rx_en) begin
          n.scl_drv = 1'b1;
          n.sda_drv = 1'b0;
          n.bitn = 4'h0;
          n.cnt = r.reload;
          n.st = S_RX_LOW;
        end
      end
      S_ST_WAIT: begin
        if (!r.scl_lvl) begin
          n.bcol = 1'b1;
          n.start_req = 1'b0;
          n.st = S_IDLE;
        end else if (tmo) begin
          if (r.sda_lvl) begin
            n.sda_drv = 1'b1;
            n.start_det = 1'b1;
            n.cnt = r.reload;
            n.st = S_ST_HOLD;
          end else begin
            n.bcol = 1'b1;
            n.start_req = 1'b0;
            n.st = S_IDLE;
          end
        end
      end
      S_ST_HOLD: begin
        if (tmo) begin
          n.start_req = 1'b0;
          n.irq = 1'b1;
          n.st = S_IDLE;
        end
      end
      S_RS_LOW: begin
        if (!r.scl_lvl) begin
          n.cnt = {1'b0, r.reload[5:0]};
          n.sda_drv = 1'b0;
          n.st = S_RS_SDA;
        end
      end
      S_RS_SDA: begin
        if (tmo) begin
          if (r.sda_lvl) begin
            n.scl_drv = 1'b0;
            n.st = S_RS_REL;
          end else begin
            n.bcol = 1'b1;
            n.restart_req = 1'b0;
            n.scl_drv = 1'b0;
            n.st = S_IDLE;
          end
        end
      end
      S_RS_REL: begin
        if (r.scl_lvl) begin
          if (!r.sda_lvl) begin
            n.bcol = 1'b1;
            n.restart_req = 1'b0;
            n.st = S_IDLE;
          end else begin
            n.cnt = r.reload;
            n.st = S_RS_HIGH;
          end
        end
      end
      S_RS_HIGH: begin
        if (!r.scl_lvl || !r.sda_lvl) begin
          n.bcol = 1'b1;
          n.restart_req = 1'b0;
          n.st = S_IDLE;
        end else if (tmo) begin
          n.sda_drv = 1'b1;
          n.start_det = 1'b1;
          n.cnt = r.reload;
          n.st = S_RS_SDALOW;
        end
      end
      S_RS_SDALOW: begin
        if (tmo) begin
          n.restart_req = 1'b0;
          n.irq = 1'b1;
          n.st = S_IDLE;
        end
      end
      S_TX_LOW: begin
        // Clock must be seen low first, else a stale high level skips the stretch wait
        if (tmo && !r.scl_lvl) begin
          n.scl_drv = 1'b0;
          n.st = S_TX_REL;
        end
      end
      S_TX_REL: begin
        if (r.scl_lvl) begin
          n.cnt = r.reload;
          n.st = S_TX_HIGH;
        end
      end
      S_TX_HIGH: begin
        if (tmo) begin
          n.scl_drv = 1'b1;
          if (r.bitn == ACK_BIT) begin
            n.ack_stat = r.sda_lvl;
            n.irq = 1'b1;
            n.st = S_IDLE;
          end else begin
            n.bitn = r.bitn + 4'h1;
            n.sh = {r.sh[6:0], 1'b0};
            n.cnt = r.reload;
            n.st = S_TX_LOW;
            if (r.bitn + 4'h1 == LAST_BIT) begin
              n.buf_full = 1'b0;
              n.sda_drv = 1'b0;
            end else begin
              n.sda_drv = !r.sh[6];
            end
          end
        end
      end
      S_RX_LOW: begin
        if (tmo && !r.scl_lvl) begin
          n.scl_drv = 1'b0;
          n.st = S_RX_REL;
        end
      end
      S_RX_REL: begin
        if (r.scl_lvl) begin
          n.cnt = r.reload;
          n.st = S_RX_HIGH;
        end
      end
      S_RX_HIGH: begin
        if (tmo) begin
          n.scl_drv = 1'b1;
          n.sh = {r.sh[6:0], r.sda_lvl};
          n.bitn = r.bitn + 4'h1;
          n.cnt = r.reload;
          n.st = S_RX_LOW;
          if (r.bitn + 4'h1 == LAST_BIT) begin
            n.rx_en = 1'b0;
            n.dbuf = {r.sh[6:0], r.sda_lvl};
            if (r.buf_full) begin
              n.ovf = 1'b1;
            end
            n.buf_full = 1'b1;
            n.irq = 1'b1;
            n.st = S_IDLE;
          end
        end
      end
      default: n.st = S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{st: S_IDLE, scl_sync: 3'h7, sda_sync: 3'h7, scl_lvl: 1'b1, sda_lvl: 1'b1,
             div: 2'h0, cnt: 7'h00, bitn: 4'h0, dbuf: BUF_RST, sh: 8'h00, reload: RELOAD_RST,
             since_wr: REWRITE_WINDOW_CYC, rdata: 32'h0000_0000, default: 1'b0};
    end else begin
      r <= n;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  cnt_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (counting(r.st) && r.cnt == 7'h00 && !tmo) |=> (r.cnt == 7'h00))
    else $error("counter left zero without reload");

  start_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == S_ST_WAIT && tmo && r.scl_lvl && r.sda_lvl) |=> (r.start_det && r.sda_drv && r.st == S_ST_HOLD))
    else $error("start edge not formed on timeout");

  start_done_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == S_ST_HOLD && tmo) |=> (!r.start_req && r.irq && r.sda_drv && r.st == S_IDLE))
    else $error("start did not complete");

  start_coll_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == S_ST_WAIT && !r.scl_lvl) |=> (r.bcol && r.st == S_IDLE && !r.sda_drv && !r.start_req))
    else $error("start collision not flagged");

  cond_coll_a: assert property (@(posedge pclk) disable iff (!presetn)
    (buf_wr && in_condition(r.st)) |=> (r.wr_coll && r.dbuf == $past(r.dbuf)))
    else $error("buffer changed during condition");

  ack_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == S_TX_HIGH && tmo && r.bitn == ACK_BIT) |=> (r.ack_stat == $past(r.sda_lvl) && r.irq && r.scl_drv))
    else $error("acknowledge not sampled");

  eighth_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == S_TX_HIGH && tmo && r.bitn == 4'h7) |=> (!r.buf_full && !r.sda_drv && r.scl_drv))
    else $error("SDA not released after eighth bit");

  stretch_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == S_TX_REL && !r.scl_lvl) |=> (r.st == S_TX_REL && $stable(r.cnt)))
    else $error("counter ran during clock stretch");

  rx_done_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == S_RX_HIGH && tmo && r.bitn == 4'h7) |=> (!r.rx_en && r.buf_full && r.irq && r.scl_drv && r.st == S_IDLE))
    else $error("reception end not handled");

endmodule

`default_nettype wire

// ### dv/i2c_slave_model.sv
`timescale 1ns/1ps
`default_nettype none

module i2c_slave_model (
  input wire logic pclk,
  input wire logic scl,
  input wire logic sda,
  input wire logic ack_en,
  input wire logic [3:0] stretch,
  input wire logic rx_mode,
  input wire logic [7:0] rx_byte,
  input wire logic hold_low,
  output logic scl_pull,
  output logic sda_pull,
  output logic [7:0] got_byte,
  output logic [7:0] start_cnt
);
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic ack_r = 1'b0;
  logic [3:0] rises = 4'h0;
  logic [3:0] falls = 4'h0;
  logic [3:0] hold_cnt = 4'h0;
  logic [7:0] sh = 8'h00;
  logic [2:0] idx;

  initial begin
    got_byte = 8'h00;
    start_cnt = 8'h00;
  end

  always @(posedge pclk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (hold_cnt != 4'h0) begin
      hold_cnt <= hold_cnt - 4'h1;
    end
    if (scl && scl_q && sda_q && !sda) begin
      start_cnt <= start_cnt + 8'h01;
      rises <= 4'h0;
    end else if (scl && !scl_q && !rx_mode) begin
      sh <= {sh[6:0], sda};
      rises <= rises + 4'h1;
      if (rises == 4'h7) begin
        got_byte <= {sh[6:0], sda};
      end
    end else if (!scl && scl_q) begin
      hold_cnt <= stretch;
      ack_r <= ack_en && (rises == 4'h8) && !rx_mode;
      if (rises == 4'h9) begin
        rises <= 4'h0;
      end
      if (rx_mode) begin
        falls <= falls + 4'h1;
      end
    end
    if (!rx_mode) begin
      falls <= 4'h0;
    end
  end

  // Data changes only while SCL is low, after each falling edge
  assign idx = 3'h7 - falls[2:0];
  assign scl_pull = hold_low || (hold_cnt != 4'h0);
  assign sda_pull = hold_low || ack_r || (rx_mode && (falls < 4'h8) && !rx_byte[idx]);
endmodule

`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import i2c_seq_pkg::*;
  localparam logic [31:0] START_M = 32'h1 << START_REQ_POS;
  localparam logic [31:0] RESTART_M = 32'h1 << RESTART_REQ_POS;
  localparam logic [31:0] RXEN_M = 32'h1 << RX_EN_POS;
  localparam logic [31:0] ACK_M = 32'h1 << ACK_STAT_POS;
  localparam logic [31:0] FULL_M = 32'h1 << BUF_FULL_POS;
  localparam logic [31:0] DET_M = 32'h1 << START_DET_POS;
  localparam logic [31:0] IRQ_M = 32'h1 << PORT_IRQ_POS;
  localparam logic [31:0] COLL_M = 32'h1 << COLL_IRQ_POS;
  localparam logic [31:0] WRCOLL_M = 32'h1 << WR_COLL_POS;
  localparam logic [31:0] OVF_M = 32'h1 << RX_OVF_POS;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  line_drive_t line_drv;
  logic scl_w;
  logic sda_w;
  logic s_scl_pull;
  logic s_sda_pull;
  logic ack_en = 1'b1;
  logic [3:0] stretch = 4'h0;
  logic rx_mode = 1'b0;
  logic [7:0] rx_byte = 8'h00;
  logic hold_low = 1'b0;
  logic [7:0] got_byte;
  logic [7:0] start_cnt;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;

  always #10 pclk = ~pclk;

  // Open-drain lines with pull-ups
  assign scl_w = !((line_drv.scl_oe && !line_drv.scl_o) || s_scl_pull);
  assign sda_w = !((line_drv.sda_oe && !line_drv.sda_o) || s_sda_pull);

  i2c_master_condition_sequencer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_i(scl_w), .sda_i(sda_w), .line_drv(line_drv));

  i2c_slave_model slave (.pclk(pclk), .scl(scl_w), .sda(sda_w), .ack_en(ack_en), .stretch(stretch),
    .rx_mode(rx_mode), .rx_byte(rx_byte), .hold_low(hold_low), .scl_pull(s_scl_pull),
    .sda_pull(s_sda_pull), .got_byte(got_byte), .start_cnt(start_cnt));

  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic check_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string what);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r & m, exp, what);
  endtask

  // Polls the event flags; a hang is cut by the cycle ceiling
  task automatic wait_flag(input logic [31:0] m);
    logic [31:0] r;
    logic e;
    r = 32'h0;
    while ((r & m) == 32'h0) apb(1'b0, EVENT_FLAGS_OFS, 32'h0, r, e);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    check_reg(PORT_STATUS_OFS, 32'hffffffff, 32'h0, "status after reset");
    check_reg(EVENT_FLAGS_OFS, 32'hffffffff, 32'h0, "flags after reset");
    apb(1'b0, 8'h40, 32'h0, r, e);
    check({31'h0, e}, 32'h1, "unmapped access error");
    wr(RELOAD_VALUE_OFS, 32'h90);
    check_reg(RELOAD_VALUE_OFS, 32'hff, 32'h10, "reload keeps seven bits");
  endtask

  task automatic t_collision();
    hold_low <= 1'b1;
    wr(EVENT_FLAGS_OFS, 32'hf);
    wr(SEQ_CONTROL_OFS, START_M);
    wait_flag(COLL_M);
    check_reg(SEQ_CONTROL_OFS, START_M, 32'h0, "start aborted");
    check({31'h0, line_drv.sda_oe}, 32'h0, "lines left alone");
    hold_low <= 1'b0;
    wr(EVENT_FLAGS_OFS, 32'hf);
    // Lines high at the begin, clock pulled low during the first period
    wr(SEQ_CONTROL_OFS, START_M);
    hold_low <= 1'b1;
    wait_flag(COLL_M);
    check_reg(SEQ_CONTROL_OFS, START_M, 32'h0, "clock low aborts start");
    check({30'h0, line_drv.sda_oe, line_drv.scl_oe}, 32'h0, "lines released on abort");
    hold_low <= 1'b0;
    wr(EVENT_FLAGS_OFS, 32'hf);
  endtask

  task automatic t_start();
    logic [7:0] s0;
    s0 = start_cnt;
    wr(SEQ_CONTROL_OFS, START_M);
    wr(DATA_BUFFER_OFS, 32'h11);
    wr(SEQ_CONTROL_OFS, RXEN_M);
    wait_flag(IRQ_M);
    check({24'h0, start_cnt - s0}, 32'h1, "one start on wire");
    check_reg(PORT_STATUS_OFS, DET_M, DET_M, "start detected");
    check_reg(SEQ_CONTROL_OFS, 32'h1f, 32'h0, "request cleared, nothing queued");
    check({30'h0, line_drv.sda_oe, line_drv.scl_oe}, 32'h2, "data held low");
    check_reg(EVENT_FLAGS_OFS, IRQ_M | WRCOLL_M, IRQ_M | WRCOLL_M, "irq and collision");
    check_reg(DATA_BUFFER_OFS, 32'hff, {24'h0, BUF_RST}, "buffer untouched");
    wr(EVENT_FLAGS_OFS, 32'hf);
    wr(RELOAD_VALUE_OFS, 32'h1);
  endtask

  task automatic t_tx(input logic [7:0] b, input logic ack, input logic [3:0] st);
    logic [7:0] s0;
    ack_en <= ack;
    stretch <= st;
    s0 = start_cnt;
    wr(DATA_BUFFER_OFS, {24'h0, b});
    wr(DATA_BUFFER_OFS, {24'h0, ~b});
    check_reg(PORT_STATUS_OFS, FULL_M, FULL_M, "full while shifting");
    wr(SEQ_CONTROL_OFS, RESTART_M);
    wr(DATA_BUFFER_OFS, {24'h0, b});
    wait_flag(IRQ_M);
    check({24'h0, got_byte}, {24'h0, b}, "byte on wire");
    check({24'h0, start_cnt - s0}, 32'h0, "no restart mid byte");
    check_reg(SEQ_CONTROL_OFS, ACK_M | RESTART_M, ack ? 32'h0 : ACK_M, "ack status");
    check_reg(PORT_STATUS_OFS, FULL_M, 32'h0, "full cleared");
    check_reg(DATA_BUFFER_OFS, 32'hff, {24'h0, ~b}, "early rewrite kept, late one dropped");
    check_reg(EVENT_FLAGS_OFS, WRCOLL_M, WRCOLL_M, "late rewrite flagged");
    check({31'h0, line_drv.scl_oe}, 32'h1, "clock held low");
    wr(EVENT_FLAGS_OFS, 32'hf);
  endtask

  task automatic t_restart();
    logic [7:0] s0;
    s0 = start_cnt;
    wr(SEQ_CONTROL_OFS, RESTART_M);
    wait_flag(IRQ_M);
    check({24'h0, start_cnt - s0}, 32'h1, "repeated start on wire");
    check_reg(SEQ_CONTROL_OFS, RESTART_M, 32'h0, "restart cleared");
    check_reg(PORT_STATUS_OFS, DET_M, DET_M, "start detected");
    check({31'h0, line_drv.sda_oe}, 32'h1, "data held low");
    wr(EVENT_FLAGS_OFS, 32'hf);
  endtask

  task automatic t_rx(input logic [7:0] b, input logic first);
    rx_byte <= b;
    rx_mode <= 1'b1;
    wr(SEQ_CONTROL_OFS, RXEN_M);
    wait_flag(IRQ_M);
    rx_mode <= 1'b0;
    check_reg(SEQ_CONTROL_OFS, RXEN_M, 32'h0, "receive enable cleared");
    check_reg(PORT_STATUS_OFS, FULL_M, FULL_M, "byte ready");
    check_reg(EVENT_FLAGS_OFS, OVF_M, first ? 32'h0 : OVF_M, "overflow");
    check({31'h0, line_drv.scl_oe}, 32'h1, "clock held low");
    wr(EVENT_FLAGS_OFS, 32'hf);
  endtask

  // ----------------------------------------
  // Verdict and run control
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors++;
      print_verdict();
    end
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_collision();
    t_start();
    t_tx(8'ha5, 1'b1, 4'h0);
    t_tx(8'h3c, 1'b0, 4'h6);
    t_restart();
    t_tx(8'h69, 1'b1, 4'h0);
    t_rx(8'h96, 1'b1);
    check_reg(DATA_BUFFER_OFS, 32'hff, 32'h96, "received msb first");
    check_reg(PORT_STATUS_OFS, FULL_M, 32'h0, "read empties buffer");
    t_rx(8'h5a, 1'b1);
    t_rx(8'hc3, 1'b0);
    print_verdict();
  end
endmodule

`default_nettype wire
